// [shared/wd_map.svh]
`ifndef WD_MAP_SVH
`define WD_MAP_SVH
// register byte addresses
`define WD_ADDR_CTRL     3'h0
`define WD_ADDR_COUNT    3'h4
// control register values per reset source
`define WD_CTRL_HW       16'h001c
`define WD_CTRL_SW       16'h0004
`define WD_CTRL_WDT      16'h0006
// control register fields
`define WD_SEL_BIT       0
`define WD_OVF_BIT       1
`define WD_INIT_CLR_MSB  7
`define WD_INIT_CLR_LSB  1
`define WD_RELOAD_MSB    15
`define WD_RELOAD_LSB    8
// counter values
`define WD_COUNT_START   16'h0000
`define WD_COUNT_MAX     16'hffff
`define WD_LOW_BYTE      8'h00
// prescaler terminal counts: /2 and /128
`define WD_DIV_FAST      7'h01
`define WD_DIV_SLOW      7'h7f
`define WD_DIV_ZERO      7'h00
// internal reset sequence, 516 cycles counted 515 down to 0
`define WD_SEQ_LAST      10'h203
`define WD_SEQ_ZERO      10'h000
`endif

// [shared/wd_pkg.sv]
package wd_pkg;
	typedef enum logic [1:0] {
		st_run,
		st_drain,
		st_seq
	} wd_state_e;
endpackage : wd_pkg

// [tb/cpu_core_model.sv]
`timescale 1ns/1ps
module cpu_core_model (
	// clock
	input  wire logic clk_sys,
	// command strobes
	output logic      service_command,
	output logic      command_format_ok,
	output logic      disable_command,
	output logic      end_of_init_command,
	output logic      software_reset_command
);
	initial begin
		service_command = 1'b0;
		command_format_ok = 1'b1;
		disable_command = 1'b0;
		end_of_init_command = 1'b0;
		software_reset_command = 1'b0;
	end
	// k: 0 service, 1 disable, 2 end of init, 3 software reset
	task automatic issue(input int k, input logic ok);
		@(posedge clk_sys);
		command_format_ok <= ok;
		service_command <= (k == 0);
		disable_command <= (k == 1);
		end_of_init_command <= (k == 2);
		software_reset_command <= (k == 3);
		@(posedge clk_sys);
		command_format_ok <= 1'b1;
		service_command <= 1'b0;
		disable_command <= 1'b0;
		end_of_init_command <= 1'b0;
		software_reset_command <= 1'b0;
	endtask : issue
endmodule : cpu_core_model

// [tb/watchdog_timer_tb.sv]
`timescale 1ns/1ps
module watchdog_timer_tb;
	logic clk_sys, rst, rd, wr, fault_seen, abort_seen;
	logic act, rdy_mode, rdy_seen, pin_n, bsl_n;
	logic [2:0] adr;
	logic [31:0] wdat, rdat, d;
	logic wreq, svc, ok, dis, eoi, software_reset_flag, pf, ab, rsto_n, irst;
	int err_count, comparisons, cycles, n;
	// ==========
	// harness
	cpu_core_model u_core (.clk_sys(clk_sys), .service_command(svc), .command_format_ok(ok),
		.disable_command(dis), .end_of_init_command(eoi), .software_reset_command(software_reset_flag));
	watchdog_timer u_dut (.clk_sys(clk_sys), .rst(rst), .avs_address(adr), .avs_read(rd), .avs_write(wr),
		.avs_byteenable(4'hf), .avs_writedata(wdat), .avs_readdata(rdat), .avs_waitrequest(wreq),
		.service_command(svc), .command_format_ok(ok), .disable_command(dis),
		.end_of_init_command(eoi), .software_reset_command(software_reset_flag), .protection_fault(pf),
		.ext_bus_active(act), .ext_bus_ready_mode(rdy_mode), .ext_bus_ready_seen(rdy_seen),
		.bus_abort(ab), .external_reset_input_n(pin_n), .bootstrap_loader_mode_n(bsl_n),
		.reset_indication_output_n(rsto_n), .internal_reset(irst));
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (pf === 1'b1) fault_seen <= 1'b1;
		if (ab === 1'b1) abort_seen <= 1'b1;
		if (cycles == 30000) begin
			err_count++;
			report_and_stop();
		end
	end
	// ==========
	// shared tasks
	task automatic report_and_stop();
		$display("errors %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk
	task automatic av(input logic w, input logic [2:0] a, input logic [31:0] wd, output logic [31:0] q);
		@(posedge clk_sys);
		adr <= a;
		wdat <= wd;
		rd <= !w;
		wr <= w;
		do @(posedge clk_sys); while (wreq !== 1'b0);
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask : av
	task automatic rate(input int k, input logic [31:0] e, input string m);
		logic [31:0] a, b;
		av(0, 3'h4, 0, a);
		repeat (k) @(posedge clk_sys);
		av(0, 3'h4, 0, b);
		chk(b - a, e, m);
	endtask : rate
	task automatic wait_run();
		while (irst !== 1'b0) @(posedge clk_sys);
	endtask : wait_run
	// ==========
	// scenarios
	task automatic t_hw();
		av(0, 3'h0, 0, d);
		chk(d, 32'h1c, "hw ctrl");
		av(0, 3'h5, 0, d);
		chk(d, 32'h0, "unmapped");
		wait_run();
		rate(253, 128, "div2");
	endtask : t_hw
	task automatic t_disable();
		u_core.issue(1, 1'b1);
		rate(253, 0, "disabled");
		u_core.issue(3, 1'b1);
		av(0, 3'h0, 0, d);
		chk(d, 32'h4, "sw ctrl");
		wait_run();
		rate(253, 128, "re-enabled");
	endtask : t_disable
	task automatic t_init();
		u_core.issue(2, 1'b1);
		av(0, 3'h0, 0, d);
		chk(d, 32'h0, "init clear");
		u_core.issue(1, 1'b1);
		rate(253, 128, "late disable");
	endtask : t_init
	task automatic t_sel();
		av(1, 3'h0, 32'h1, d);
		av(1, 3'h4, 32'h0, d);
		av(0, 3'h0, 0, d);
		chk(d, 32'h1, "select");
		rate(1021, 8, "div128");
		u_core.issue(0, 1'b0);
		repeat (2) @(posedge clk_sys);
		chk(fault_seen, 1, "fault");
		av(0, 3'h4, 0, d);
		chk(d > 32'h100, 1, "no service");
	endtask : t_sel
	task automatic t_ovf();
		av(1, 3'h0, 32'hff00, d);
		act <= 1'b1;
		rdy_mode <= 1'b1;
		u_core.issue(0, 1'b1);
		av(0, 3'h4, 0, d);
		chk(d >> 8, 32'hff, "reload");
		n = 0;
		while (rsto_n !== 1'b0) begin
			@(posedge clk_sys);
			n++;
		end
		chk(n >= 500 && n <= 512, 1, "period");
		@(posedge clk_sys);
		chk(abort_seen, 1, "abort");
		act <= 1'b0;
		av(0, 3'h0, 0, d);
		chk(d, 32'h6, "wd ctrl");
		wait_run();
		u_core.issue(0, 1'b1);
		av(0, 3'h0, 0, d);
		chk(d, 32'h4, "flag clear");
		av(1, 3'h0, 32'hff00, d);
		rdy_seen <= 1'b1;
		act <= 1'b1;
		u_core.issue(0, 1'b1);
		repeat (520) @(posedge clk_sys);
		chk(rsto_n, 1, "bus cycle completes first");
		act <= 1'b0;
		repeat (3) @(posedge clk_sys);
		chk(rsto_n, 0, "reset after bus cycle");
	endtask : t_ovf
	task automatic t_pin();
		bsl_n <= 1'b0;
		pin_n <= 1'b0;
		repeat (8) @(posedge clk_sys);
		av(0, 3'h0, 0, d);
		chk(d, 32'h1c, "pin ctrl");
		pin_n <= 1'b1;
		wait_run();
		bsl_n <= 1'b1;
		rate(253, 0, "bootstrap");
	endtask : t_pin
	initial begin
		rst = 1'b1;
		rd = 1'b0;
		wr = 1'b0;
		adr = 3'h0;
		wdat = 32'h0;
		act = 1'b0;
		rdy_mode = 1'b0;
		rdy_seen = 1'b0;
		pin_n = 1'b1;
		bsl_n = 1'b1;
		fault_seen = 1'b0;
		abort_seen = 1'b0;
		err_count = 0;
		comparisons = 0;
		cycles = 0;
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		t_hw();
		t_disable();
		t_init();
		t_sel();
		t_ovf();
		t_pin();
		report_and_stop();
	end
endmodule : watchdog_timer_tb

// [verilog/watchdog_timer.sv]
// Contract
// - hardware reset loads control with 001C
// - software reset loads control with 0004
// - overflow reset loads control with 0006
// - end-of-init clears control bits 7..1
// - after reset count from zero, divide two
// - select bit set counts at divide 128
// - disable honoured only before init or service
// - counts only in run state unless disabled; holds while draining, zero during reset
// - overflow past FFFF starts reset, output low
// - overflow flag cleared by hardware reset, service
// - overflow lets bus cycle finish or aborts
// - bootstrap mode after hardware reset disables
// - service clears low byte, loads reload
// - after service count resumes from reload*256
// - malformed service traps, no servicing
// - period is 2^(1+6sel)*(65536-reload*256) cycles
// - 16-bit counter readable, not writable
// - control bit 0 selects divide two or 128
//
// Implementation choices: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
`include "wd_map.svh"
module watchdog_timer (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// avalon-mm slave
	input  wire logic [2:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [3:0]  avs_byteenable,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// core command strobes
	input  wire logic        service_command,
	input  wire logic        command_format_ok,
	input  wire logic        disable_command,
	input  wire logic        end_of_init_command,
	input  wire logic        software_reset_command,
	output logic             protection_fault,
	// external bus status
	input  wire logic        ext_bus_active,
	input  wire logic        ext_bus_ready_mode,
	input  wire logic        ext_bus_ready_seen,
	output logic             bus_abort,
	// pins
	input  wire logic        external_reset_input_n,
	input  wire logic        bootstrap_loader_mode_n,
	output logic             reset_indication_output_n,
	output logic             internal_reset
);
	// ==========================================================
	// pin synchronisers
	logic pin_rst_m, pin_rst_s, pin_bsl_m, pin_bsl_s;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pin_rst_m <= 1'b1;
			pin_rst_s <= 1'b1;
			pin_bsl_m <= 1'b1;
			pin_bsl_s <= 1'b1;
		end else begin
			pin_rst_m <= external_reset_input_n;
			pin_rst_s <= pin_rst_m;
			pin_bsl_m <= bootstrap_loader_mode_n;
			pin_bsl_s <= pin_bsl_m;
		end
	end

	// ==========================================================
	// watchdog core
	wd_pkg::wd_state_e state, next_state;
	logic [15:0] watchdog_control_register, next_ctrl;
	logic [15:0] watchdog_count_register, next_count;
	logic [6:0]  presc, next_presc;
	logic [9:0]  seq_cnt, next_seq_cnt;
	logic        enabled, next_enabled;
	logic        init_done, next_init_done;
	logic        hw_cause, next_hw_cause;
	logic        next_fault, next_abort;
	logic        tick, service_ok, overflow, fire, ctrl_wr;
	logic [31:0] next_readdata;
	logic        next_waitrequest;

	always_comb begin
		tick       = (presc == (watchdog_control_register[`WD_SEL_BIT] ? `WD_DIV_SLOW : `WD_DIV_FAST));
		service_ok = service_command && command_format_ok && (state == wd_pkg::st_run);
		overflow   = (state == wd_pkg::st_run) && enabled && tick && !service_ok && !software_reset_command
			&& (watchdog_count_register == `WD_COUNT_MAX);
		fire       = (state == wd_pkg::st_drain) &&
			(!ext_bus_active || (ext_bus_ready_mode && !ext_bus_ready_seen));
		ctrl_wr    = avs_write && !avs_waitrequest && (avs_address == `WD_ADDR_CTRL);
	end

	always_comb begin
		next_state     = state;
		next_ctrl      = watchdog_control_register;
		next_count     = watchdog_count_register;
		next_presc     = presc;
		next_seq_cnt   = seq_cnt;
		next_enabled   = enabled;
		next_init_done = init_done;
		next_hw_cause  = hw_cause;
		next_fault     = service_command && !command_format_ok && (state == wd_pkg::st_run);
		next_abort     = fire && ext_bus_active;
		if (!pin_rst_s) begin
			next_state    = wd_pkg::st_seq;
			next_ctrl     = `WD_CTRL_HW;
			next_seq_cnt  = `WD_SEQ_LAST;
			next_hw_cause = 1'b1;
			next_enabled  = 1'b0;
			next_count    = `WD_COUNT_START;
			next_presc    = `WD_DIV_ZERO;
			next_abort    = 1'b0;
		end else begin
			unique case (state)
				wd_pkg::st_run: begin
					if (ctrl_wr) begin
						if (avs_byteenable[1])
							next_ctrl[`WD_RELOAD_MSB:`WD_RELOAD_LSB] = avs_writedata[`WD_RELOAD_MSB:`WD_RELOAD_LSB];
						if (avs_byteenable[0])
							next_ctrl[`WD_SEL_BIT] = avs_writedata[`WD_SEL_BIT];
					end
					if (enabled)
						next_presc = tick ? `WD_DIV_ZERO : presc + 7'h01;
					if (enabled && tick)
						next_count = watchdog_count_register + 16'h0001;
					if (disable_command && !init_done)
						next_enabled = 1'b0;
					if (end_of_init_command) begin
						next_ctrl[`WD_INIT_CLR_MSB:`WD_INIT_CLR_LSB] = 7'h00;
						next_init_done = 1'b1;
					end
					if (service_ok) begin
						next_count = {watchdog_control_register[`WD_RELOAD_MSB:`WD_RELOAD_LSB],
							`WD_LOW_BYTE};
						next_presc = `WD_DIV_ZERO;
						next_ctrl[`WD_OVF_BIT] = 1'b0;
						next_init_done = 1'b1;
					end
					if (software_reset_command) begin
						next_state   = wd_pkg::st_seq;
						next_ctrl    = `WD_CTRL_SW;
						next_seq_cnt = `WD_SEQ_LAST;
						next_enabled = 1'b0;
					end else if (overflow)
						next_state = wd_pkg::st_drain;
				end
				wd_pkg::st_drain: begin
					if (fire) begin
						next_state   = wd_pkg::st_seq;
						next_ctrl    = `WD_CTRL_WDT;
						next_seq_cnt = `WD_SEQ_LAST;
						next_enabled = 1'b0;
					end
				end
				wd_pkg::st_seq: begin
					next_count = `WD_COUNT_START;
					next_presc = `WD_DIV_ZERO;
					if (seq_cnt != `WD_SEQ_ZERO)
						next_seq_cnt = seq_cnt - 10'h001;
					else begin
						next_state     = wd_pkg::st_run;
						next_enabled   = !(hw_cause && !pin_bsl_s);
						next_init_done = 1'b0;
						next_hw_cause  = 1'b0;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state                     <= wd_pkg::st_seq;
			watchdog_control_register <= `WD_CTRL_HW;
			watchdog_count_register   <= `WD_COUNT_START;
			presc                     <= `WD_DIV_ZERO;
			seq_cnt                   <= `WD_SEQ_LAST;
			enabled                   <= 1'b0;
			init_done                 <= 1'b0;
			hw_cause                  <= 1'b1;
			protection_fault          <= 1'b0;
			bus_abort                 <= 1'b0;
			reset_indication_output_n <= 1'b0;
			internal_reset            <= 1'b1;
		end else begin
			state                     <= next_state;
			watchdog_control_register <= next_ctrl;
			watchdog_count_register   <= next_count;
			presc                     <= next_presc;
			seq_cnt                   <= next_seq_cnt;
			enabled                   <= next_enabled;
			init_done                 <= next_init_done;
			hw_cause                  <= next_hw_cause;
			protection_fault          <= next_fault;
			bus_abort                 <= next_abort;
			reset_indication_output_n <= (next_state != wd_pkg::st_seq);
			internal_reset            <= (next_state == wd_pkg::st_seq);
		end
	end

	// ==========================================================
	// avalon slave: one wait cycle, then answer
	always_comb begin
		next_waitrequest = !((avs_read || avs_write) && avs_waitrequest);
		next_readdata    = avs_readdata;
		if (avs_read && avs_waitrequest) begin
			unique case (avs_address)
				`WD_ADDR_CTRL:  next_readdata = {16'h0000, watchdog_control_register};
				`WD_ADDR_COUNT: next_readdata = {16'h0000, watchdog_count_register};
				default:        next_readdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0000_0000;
		end else begin
			avs_waitrequest <= next_waitrequest;
			avs_readdata    <= next_readdata;
		end
	end

	// ==========================================================
	// assertions
	property p_hw_value;
		@(posedge clk_sys) disable iff (rst)
		!pin_rst_s |=> (watchdog_control_register == `WD_CTRL_HW) && internal_reset;
	endproperty
	a_hw_value: assert property (p_hw_value) else $error("hardware reset value wrong");

	property p_sw_value;
		@(posedge clk_sys) disable iff (rst)
		(software_reset_command && state == wd_pkg::st_run && pin_rst_s)
			|=> (watchdog_control_register == `WD_CTRL_SW) && !reset_indication_output_n;
	endproperty
	a_sw_value: assert property (p_sw_value) else $error("software reset value wrong");

	property p_wdt_value;
		@(posedge clk_sys) disable iff (rst)
		(fire && pin_rst_s) |=> (watchdog_control_register == `WD_CTRL_WDT) && internal_reset;
	endproperty
	a_wdt_value: assert property (p_wdt_value) else $error("overflow reset value wrong");

	property p_end_of_init_command;
		@(posedge clk_sys) disable iff (rst)
		(end_of_init_command && state == wd_pkg::st_run && !software_reset_command && pin_rst_s)
			|=> (watchdog_control_register[`WD_INIT_CLR_MSB:`WD_INIT_CLR_LSB] == 7'h00);
	endproperty
	a_end_of_init_command: assert property (p_end_of_init_command) else $error("end of init left flags set");

	property p_start;
		@(posedge clk_sys) disable iff (rst)
		$fell(internal_reset) |-> (watchdog_count_register == `WD_COUNT_START) && (presc == `WD_DIV_ZERO);
	endproperty
	a_start: assert property (p_start) else $error("count not zero after reset");

	property p_div_slow;
		@(posedge clk_sys) disable iff (rst)
		(tick && watchdog_control_register[`WD_SEL_BIT] && enabled)
			|=> (!tick || !watchdog_control_register[`WD_SEL_BIT]) [*8];
	endproperty
	a_div_slow: assert property (p_div_slow) else $error("slow divider ticks too soon");

	property p_disable_locked;
		@(posedge clk_sys) disable iff (rst)
		(disable_command && init_done && state == wd_pkg::st_run && pin_rst_s && !software_reset_command)
			|=> enabled == $past(enabled);
	endproperty
	a_disable_locked: assert property (p_disable_locked) else $error("late disable took effect");

	property p_overflow;
		@(posedge clk_sys) disable iff (rst)
		(overflow && pin_rst_s) |=> (state == wd_pkg::st_drain);
	endproperty
	a_overflow: assert property (p_overflow) else $error("overflow not taken");

	property p_service;
		@(posedge clk_sys) disable iff (rst)
		(service_ok && !software_reset_command && pin_rst_s)
			|=> (watchdog_count_register ==
			{$past(watchdog_control_register[`WD_RELOAD_MSB:`WD_RELOAD_LSB]), `WD_LOW_BYTE})
			&& !watchdog_control_register[`WD_OVF_BIT];
	endproperty
	a_service: assert property (p_service) else $error("service did not reload");

	property p_abort;
		@(posedge clk_sys) disable iff (rst)
		(state == wd_pkg::st_drain && ext_bus_active && ext_bus_ready_mode && !ext_bus_ready_seen && pin_rst_s)
			|=> bus_abort ##1 !bus_abort;
	endproperty
	a_abort: assert property (p_abort) else $error("bus cycle not aborted");

	property p_fault;
		@(posedge clk_sys) disable iff (rst)
		(service_command && !command_format_ok && state == wd_pkg::st_run && pin_rst_s)
			|=> protection_fault && (watchdog_count_register !=
			{$past(watchdog_control_register[`WD_RELOAD_MSB:`WD_RELOAD_LSB]),
			`WD_LOW_BYTE} || $past(watchdog_count_register) + 16'h0001 == watchdog_count_register
			|| $past(watchdog_count_register) == watchdog_count_register);
	endproperty
	a_fault: assert property (p_fault) else $error("malformed service not trapped");

	c_overflow: cover property (@(posedge clk_sys) disable iff (rst) fire);
	c_service: cover property (@(posedge clk_sys) disable iff (rst) service_ok);
	c_disable: cover property (@(posedge clk_sys) disable iff (rst) disable_command && !init_done && enabled);
endmodule : watchdog_timer
